// >>> design/cfgx_pkg.sv
// constants for the configuration extension port
package cfgx_pkg;
    localparam int REG_W = 10;
    localparam int FUNC_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam logic [9:0] LEG_LO = 10'h010;
    localparam logic [9:0] LEG_HI = 10'h01F;
    localparam logic [9:0] EXT_LO = 10'h100;
    localparam logic [9:0] EXT_HI = 10'h3FF;
    localparam logic [9:0] REG_RST = 10'h000;
    localparam logic [7:0] FUNC_RST = 8'h00;
    localparam logic [31:0] DATA_RST = 32'h00000000;
    localparam logic [3:0] BE_RST = 4'h0;
    typedef enum logic [1:0] {CFGX_IDLE, CFGX_PULSE, CFGX_WAIT} cfgx_state_t;
endpackage

// >>> design/cfgx_rdcap.sv
// read data capture register for user-answered reads
`timescale 1ns/1ns
`default_nettype none
module cfgx_rdcap
    import cfgx_pkg::*;
#(
    parameter int W = DATA_W
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    input  wire logic         load,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] data_reg;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_reg <= '0;
        end else if (ce && load) begin
            data_reg <= din;
        end
    end
    assign dout = data_reg;
endmodule
`default_nettype wire

// >>> design/cfgx_port.sv
// configuration extension port: forwards link config accesses to user logic
// Contract
// - read_received is raised for every configuration read taken from the link.
// - with no user space enabled, a read gives a one-cycle read_received with reg and func.
// - a read into an enabled user range holds read_received until read_data_valid.
// - a read outside both user ranges always gives a one-cycle read_received.
// - every configuration write taken in idle without link_rd gives exactly one cycle of write_received.
// - a 10-bit register number is valid while read_received or write_received is high.
// - an 8-bit function number is valid while read_received or write_received is high.
// - 32-bit write data is valid while write_received is high.
// - a 4-bit byte enable qualifies the bytes of the write data.
// - for a read into an enabled user range, read data is sampled on the edge after read_received when read_data_valid is set.
// - for a read into an enabled user range, read_data_valid is sampled on the edge after read_received is raised.
`timescale 1ns/1ns
`default_nettype none
module cfgx_port
    import cfgx_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              ce,
    input  wire logic              legacy_en,
    input  wire logic              ext_en,
    input  wire logic              link_rd,
    input  wire logic              link_wr,
    input  wire logic [REG_W-1:0]  link_reg,
    input  wire logic [FUNC_W-1:0] link_func,
    input  wire logic [DATA_W-1:0] link_wdata,
    input  wire logic [BE_W-1:0]   link_be,
    output logic                   link_busy,
    output logic                   link_rd_done,
    output logic                   link_rd_user,
    output logic [DATA_W-1:0]      link_rdata,
    output logic                   read_received,
    output logic                   write_received,
    output logic [REG_W-1:0]       register_number,
    output logic [FUNC_W-1:0]      function_number,
    output logic [DATA_W-1:0]      write_data,
    output logic [BE_W-1:0]        write_byte_enable,
    input  wire logic [DATA_W-1:0] read_data,
    input  wire logic              read_data_valid
);
    function automatic logic in_user(
        input logic [REG_W-1:0] r,
        input logic             le,
        input logic             ee
    );
        logic in_leg;
        logic in_ext;
        in_leg  = le && (r >= LEG_LO) && (r <= LEG_HI);
        in_ext  = ee && (r >= EXT_LO) && (r <= EXT_HI);
        in_user = in_leg || in_ext;
    endfunction

    cfgx_state_t state_reg, state_next;
    logic              rr_reg, wr_reg, busy_reg, done_reg, user_reg;
    logic [REG_W-1:0]  regn_reg;
    logic [FUNC_W-1:0] func_reg;
    logic [DATA_W-1:0] wdat_reg;
    logic [BE_W-1:0]   be_reg;

    // a write arriving while a user read waits is refused; link_busy tells the link side
    wire idle      = (state_reg == CFGX_IDLE);
    wire take_rd   = idle && link_rd;
    wire take_wr   = idle && !link_rd && link_wr;
    wire user_rd   = in_user(link_reg, legacy_en, ext_en);
    wire waiting   = (state_reg == CFGX_WAIT);
    wire answered  = waiting && read_data_valid;
    wire take_any  = take_rd || take_wr;
    // held through the wait, dropped on the valid edge
    wire hold_rd   = waiting && !read_data_valid;
    wire rr_next   = take_rd || hold_rd;
    wire busy_next = (take_rd && user_rd) || hold_rd;
    wire done_next = answered || (state_reg == CFGX_PULSE);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CFGX_IDLE: begin
                if (take_rd) begin
                    state_next = user_rd ? CFGX_WAIT : CFGX_PULSE;
                end
            end
            CFGX_PULSE: begin
                state_next = CFGX_IDLE;
            end
            CFGX_WAIT: begin
                if (read_data_valid) begin
                    state_next = CFGX_IDLE;
                end
            end
            default: begin
                state_next = CFGX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= CFGX_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rr_reg   <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            user_reg <= 1'b0;
        end else if (ce) begin
            rr_reg   <= rr_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            user_reg <= answered;
        end
    end

    // a write never waits, so back to back writes keep write_received high
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_reg   <= 1'b0;
            wdat_reg <= DATA_RST;
            be_reg   <= BE_RST;
        end else if (ce) begin
            wr_reg <= take_wr;
            if (take_wr) begin
                wdat_reg <= link_wdata;
                be_reg   <= link_be;
            end
        end
    end

    // fields hold until the next taken request, past the end of the indication
    always_ff @(posedge clk) begin
        if (!resetn) begin
            regn_reg <= REG_RST;
            func_reg <= FUNC_RST;
        end else if (ce && take_any) begin
            regn_reg <= link_reg;
            func_reg <= link_func;
        end
    end

    cfgx_rdcap #(.W(DATA_W)) u_rdcap (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .load   (answered),
        .din    (read_data),
        .dout   (link_rdata)
    );

    assign read_received     = rr_reg;
    assign write_received    = wr_reg;
    assign register_number   = regn_reg;
    assign function_number   = func_reg;
    assign write_data        = wdat_reg;
    assign write_byte_enable = be_reg;
    assign link_busy         = busy_reg;
    assign link_rd_done      = done_reg;
    assign link_rd_user      = user_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    rd_pulse_a: assert property (
        ce && take_rd && !user_rd ##1 ce |-> read_received ##1 !read_received
    ) else $error("plain read pulse not one cycle");
    plain_off_a: assert property (
        ce && take_rd && !legacy_en && !ext_en ##1 ce |-> read_received && !link_busy ##1 !read_received
    ) else $error("read with no user space not one cycle");
    rd_hold_a: assert property (
        ce && take_rd && user_rd ##1 ce && !read_data_valid |=> read_received
    ) else $error("user read dropped before valid");
    busy_wait_a: assert property (
        link_busy == waiting && (!waiting || read_received)
    ) else $error("busy flag does not follow the wait");
    rd_end_a: assert property (
        read_received && waiting && read_data_valid && ce |=> !read_received
    ) else $error("read held after valid");
    rd_cap_a: assert property (
        ce && answered |=> link_rdata == $past(read_data) && link_rd_user
    ) else $error("read data not captured");
    done_pulse_a: assert property (
        ce && state_reg == CFGX_PULSE |=> link_rd_done && !link_rd_user && !read_received
    ) else $error("plain read not finished");
    rd_always_a: assert property (
        ce && take_rd |=> read_received
    ) else $error("read not indicated");

    wr_pulse_a: assert property (
        ce && take_wr ##1 ce && !take_wr |-> write_received ##1 !write_received
    ) else $error("write pulse wrong");
    wr_refuse_a: assert property (
        ce && !idle |=> !write_received
    ) else $error("write taken while a read is open");
    wr_data_a: assert property (
        ce && take_wr |=> write_data == $past(link_wdata) && write_byte_enable == $past(link_be)
    ) else $error("write data or enables wrong");
    no_both_a: assert property (
        !(read_received && write_received)
    ) else $error("read and write together");

    reg_num_a: assert property (
        ce && take_any |=> register_number == $past(link_reg)
    ) else $error("register number wrong");
    func_num_a: assert property (
        ce && take_any |=> function_number == $past(link_func)
    ) else $error("function number wrong");
    freeze_a: assert property (
        !ce |=> $stable(read_received) && $stable(write_received)
            && $stable(link_busy) && $stable(register_number)
    ) else $error("state moved while clock enable low");

    user_read_c: cover property (ce && take_rd && user_rd ##[1:4] answered);
    plain_read_c: cover property (ce && take_rd && !user_rd);
    write_c: cover property (ce && take_wr);
    wr_b2b_c: cover property (ce && take_wr ##1 ce && take_wr);
    freeze_c: cover property (!ce && write_received);
endmodule
`default_nettype wire

// >>> tb/cfgx_user_model.sv
// user logic model answering held configuration reads
`timescale 1ns/1ns
`default_nettype none
module cfgx_user_model
    import cfgx_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              answer,
    input  wire logic [1:0]        dly,
    input  wire logic [DATA_W-1:0] word,
    input  wire logic              read_received,
    output logic      [DATA_W-1:0] read_data,
    output logic                   read_data_valid
);
    logic [1:0]        cnt_reg  = 2'h0;
    logic              rdv_reg  = 1'b0;
    logic [DATA_W-1:0] rdat_reg = '0;
    // answer is only set by the bench for a read held in a user range
    always @(posedge clk) begin
        if (rdv_reg) begin
            rdv_reg  <= 1'b0;
            rdat_reg <= ~rdat_reg; // a released bus shows no stale word
            cnt_reg  <= 2'h0;
        end else if (answer && read_received && cnt_reg == dly) begin
            rdv_reg  <= 1'b1;
            rdat_reg <= word;
        end else if (answer && read_received) begin
            cnt_reg <= cnt_reg + 2'h1;
        end
    end
    assign read_data       = rdat_reg;
    assign read_data_valid = rdv_reg;
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the configuration extension port
`timescale 1ns/1ns
`default_nettype none
module testbench
    import cfgx_pkg::*;
;
    logic clk = 0, resetn = 0, legacy_en = 0, ext_en = 0, link_rd = 0, link_wr = 0, answer = 0;
    logic [9:0] link_reg = 10'h000;
    logic [7:0] link_func = 8'h00;
    logic [31:0] link_wdata = 32'h00000000, word = 32'h00000000;
    logic [3:0] link_be = 4'h0;
    logic [1:0] dly = 2'h0;
    logic ce = 1'b1;
    logic [31:0] exp_q [$];
    wire logic busy, done, ruser, rr, wrx, rdv;
    wire logic [31:0] rdata, wd, rd_d;
    wire logic [9:0] rn;
    wire logic [7:0] fn;
    wire logic [3:0] be;
    int fail_count = 0, n_compared = 0, seed = 53340, cycles = 0, m;
    logic [9:0] tbl [8] = '{10'h00F, 10'h010, 10'h01F, 10'h020, 10'h0FF, 10'h100, 10'h3FF, 10'h1A5};
    always #2 clk = ~clk;
    cfgx_port u_dut(.clk(clk), .resetn(resetn), .ce(ce), .legacy_en(legacy_en), .ext_en(ext_en),
        .link_rd(link_rd), .link_wr(link_wr), .link_reg(link_reg), .link_func(link_func),
        .link_wdata(link_wdata), .link_be(link_be), .link_busy(busy), .link_rd_done(done),
        .link_rd_user(ruser), .link_rdata(rdata), .read_received(rr), .write_received(wrx),
        .register_number(rn), .function_number(fn), .write_data(wd), .write_byte_enable(be),
        .read_data(rd_d), .read_data_valid(rdv));
    cfgx_user_model u_user(.clk(clk), .answer(answer), .dly(dly), .word(word),
        .read_received(rr), .read_data(rd_d), .read_data_valid(rdv));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            close_out();
        end
    end
    // writes leave link_wr up unless link_be[0] is set, so that the next call makes them back to back
    task automatic xfer(input logic rd, input logic [9:0] r);
        logic user;
        int k;
        user = rd && ((legacy_en && r >= LEG_LO && r <= LEG_HI) || (ext_en && r >= EXT_LO));
        link_rd = rd;
        link_wr = !rd || 1'($random(seed));
        link_reg = r;
        link_func = 8'($random(seed));
        link_wdata = $random(seed);
        link_be = 4'($random(seed));
        answer = user;
        dly = 2'($random(seed));
        word = $random(seed);
        if (user) exp_q.push_back(word);
        @(negedge clk);
        chk(32'(rr), 32'(rd));
        chk(32'(wrx), 32'(!rd));
        chk(32'(rn), 32'(r));
        chk(32'(fn), 32'(link_func));
        chk(32'(busy), 32'(user));
        if (!rd) chk(wd, link_wdata);
        if (!rd) chk(32'(be), 32'(link_be));
        if (!rd && link_be[0]) begin
            ce = 1'b0;
            link_wr = 1'b0;
            @(negedge clk);
            chk(32'(wrx), 32'h1);
            chk(wd, link_wdata);
            ce = 1'b1;
        end
        if (rd) begin
            link_rd = 1'b0;
            link_wr = 1'b0;
            for (k = 0; k < 8 && done !== 1'b1; k++) @(negedge clk);
            chk(32'(done), 32'h1);
            chk(32'(rr), 32'h0);
            chk(32'(ruser), 32'(user));
            if (user) chk(rdata, exp_q.pop_front());
        end
    endtask
    initial begin
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        for (m = 0; m < 4; m++) begin
            {ext_en, legacy_en} = 2'(m);
            foreach (tbl[i]) begin
                xfer(1'b1, tbl[i]);
                xfer(1'b0, 10'($random(seed)));
                xfer(1'b0, tbl[i]);
            end
        end
        xfer(1'b1, 10'h000);
        close_out();
    end
endmodule
`default_nettype wire
